// ==== include/trrs_pkg.sv ====
// constants, types and report table for the timing receiver report scheduler
// assumes a 10 MHz system clock and an apb master with 8-bit byte addresses
package trrs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // framing bytes and extended packet identifiers
  localparam logic [7:0] DLE = 8'h10;
  localparam logic [7:0] ETX = 8'h03;
  localparam logic [7:0] ID_EXT_CMD = 8'h8E;
  localparam logic [7:0] ID_EXT_RPT = 8'h8F;
  localparam logic [7:0] SUB_TIM1 = 8'hAB;
  localparam logic [7:0] SUB_TIM2 = 8'hAC;

  ////////////////////////////////////////////////////////////////////////////
  // report slots; a lower index is sent first
  localparam int NS = 28;
  localparam int S_VER = 0;
  localparam int S_P41 = 1;
  localparam int S_P42 = 2;
  localparam int S_P43 = 3;
  localparam int S_P4A = 4;
  localparam int S_P56 = 5;
  localparam int S_P83 = 6;
  localparam int S_P84 = 7;
  localparam int S_P47 = 8;
  localparam int S_P6C = 9;
  localparam int S_P5A = 10;
  localparam int S_P57 = 11;
  localparam int S_P46 = 12;
  localparam int S_P4B = 13;
  localparam int S_P55 = 14;
  localparam int S_P30 = 15;
  localparam int S_P58 = 16;
  localparam int S_P59 = 17;
  localparam int S_P5D = 18;
  localparam int S_P7B = 19;
  localparam int S_P1C = 20;
  localparam int S_PBB = 21;
  localparam int S_PBC = 22;
  localparam int S_P4E = 23;
  localparam int S_P13 = 24;
  localparam int S_TM1 = 25;
  localparam int S_TM2 = 26;
  localparam int S_EXT = 27;
  localparam logic [7:0] SLOT_ID [NS] = '{
    8'h45, 8'h41, 8'h42, 8'h43, 8'h4A, 8'h56, 8'h83, 8'h84, 8'h47, 8'h6C,
    8'h5A, 8'h57, 8'h46, 8'h4B, 8'h55, 8'h30, 8'h58, 8'h59, 8'h5D, 8'h7B,
    8'h1C, 8'hBB, 8'hBC, 8'h4E, 8'h13, 8'h8F, 8'h8F, 8'h8F};

  ////////////////////////////////////////////////////////////////////////////
  // version report payload bytes 1..10, values arbitrary
  localparam int VER_LEN = 10;
  localparam logic [7:0] VER_BYTE [VER_LEN] = '{
    8'h01, 8'h00, 8'h01, 8'h01, 8'h18, 8'h02, 8'h00, 8'h01, 8'h01, 8'h18};

  ////////////////////////////////////////////////////////////////////////////
  // command identifiers
  localparam logic [7:0] C_HWVER = 8'h1C;
  localparam logic [7:0] C_RESET = 8'h1E;
  localparam logic [7:0] C_SWVER = 8'h1F;
  localparam logic [7:0] C_TIME = 8'h21;
  localparam logic [7:0] C_SVSEL = 8'h24;
  localparam logic [7:0] C_HEALTH = 8'h26;
  localparam logic [7:0] C_SIG = 8'h27;
  localparam logic [7:0] C_SETTIME = 8'h2E;
  localparam logic [7:0] C_ROLL = 8'h30;
  localparam logic [7:0] C_POSXYZ = 8'h31;
  localparam logic [7:0] C_POSLLA = 8'h32;
  localparam logic [7:0] C_IOOPT = 8'h35;
  localparam logic [7:0] C_LASTFIX = 8'h37;
  localparam logic [7:0] C_SYSDATA = 8'h38;
  localparam logic [7:0] C_SVEN = 8'h39;
  localparam logic [7:0] C_RAW = 8'h3A;
  localparam logic [7:0] C_TRACK = 8'h3C;
  localparam logic [7:0] C_INTERVAL = 8'h7A;
  localparam logic [7:0] C_RXCFG = 8'hBB;
  localparam logic [7:0] C_PORTCFG = 8'hBC;

  ////////////////////////////////////////////////////////////////////////////
  // apb register map and reset values
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_OPT = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_PEND = 8'h0C;
  localparam logic [7:0] RST_MASK = 8'h05;
  localparam logic [31:0] RST_OPT = 32'h0800_0212;
  // broadcast mask bits
  localparam int MB_TIM1 = 0;
  localparam int MB_TIM2 = 2;
  localparam int MB_AUTO = 6;
  // option bits: [7:0] position, [15:8] velocity, [31:24] auxiliary
  localparam int PO_ECEF = 0;
  localparam int PO_LLA = 1;
  localparam int PO_DBL = 4;
  localparam int VO_ECEF = 8;
  localparam int VO_ENU = 9;
  localparam int AO_RAW = 24;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int QUIET_S = 10;
  localparam int SEC_S = 1;
  localparam int QUIET_CYC = CLK_HZ * QUIET_S;
  localparam int SEC_CYC = CLK_HZ * SEC_S;
  localparam int CNT_W = 27;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [7:0] id;
    logic [7:0] sub;
  } trrs_cmd_type;

  typedef enum logic [4:0] {
    R_HUNT = 5'b00001,
    R_DLE = 5'b00010,
    R_BODY = 5'b00100,
    R_BDLE = 5'b01000,
    R_DROP = 5'b10000
  } trrs_rx_type;

  typedef enum logic [5:0] {
    T_IDLE = 6'b000001,
    T_SOF = 6'b000010,
    T_BODY = 6'b000100,
    T_STUF = 6'b001000,
    T_EOF = 6'b010000,
    T_ETX = 6'b100000
  } trrs_tx_type;

endpackage

// ==== verilog/trrs_sched.sv ====
// report scheduler and command dispatcher for the serial packet port
// assumes a byte-wide receive/transmit uart outside, apb master for control
//
// What this block does
// - fix completion broadcasts gated position/velocity reports
// - double-precision cartesian position sent on gated fixes with PO_ECEF and PO_DBL set
// - satellite list, signal levels each second, mask-gated
// - new measurements broadcast raw report when enabled
// - timing reports each second by mask bits
// - version report sent after every reset
// - version bytes 0-5: id, application version, date
// - version bytes 6-10: core revision and date
// - reset command resets then versions; version request answered
// - last fix request answers fix info plus enabled
// - accurate position loads get no response
// - rollover date command echoed with same identifier
// - satellite selection and signal level requests answered
// - raw measurement and tracking status requests answered
// - system data load/request answered with acknowledge
// - satellite enable/health command answered with status
// - interval and mask command answered with response
// - time, health, i/o option requests answered
// - extended commands answered with same subcode report
// - frames are start, id, stuffed data, end
// - multi-byte fields travel most significant first
// - commands ignored during power-up quiet time
`timescale 1ns/1ps
module trrs_sched
  import trrs_pkg::*;
#(
  parameter int QUIET_CYCLES = QUIET_CYC,
  parameter int SEC_CYCLES = SEC_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic fix_done,
  input wire logic meas_new,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic sw_reset_req,
  output logic [7:0] sw_reset_kind
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [NS-1:0] fix_rpts(input logic [31:0] opt);
    fix_rpts = '0;
    fix_rpts[S_P42] = opt[PO_ECEF];
    fix_rpts[S_P83] = opt[PO_ECEF] & opt[PO_DBL];
    fix_rpts[S_P4A] = opt[PO_LLA];
    fix_rpts[S_P84] = opt[PO_LLA] & opt[PO_DBL];
    fix_rpts[S_P43] = opt[VO_ECEF];
    fix_rpts[S_P56] = opt[VO_ENU];
  endfunction

  function automatic logic [4:0] first_one(input logic [NS-1:0] v);
    first_one = '0;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (v[i])
        first_one = 5'(i);
    end
  endfunction

  logic [7:0] mask_ff;
  logic [31:0] opt_ff;
  logic [NS-1:0] pend_ff;
  logic quiet_ff;
  logic [CNT_W-1:0] quiet_cnt_ff;
  logic [CNT_W-1:0] sec_cnt_ff;
  logic sec_tick_ff;
  trrs_rx_type rx_st_ff;
  trrs_cmd_type cmd_ff;
  logic got_sub_ff;
  logic cmd_done_ff;
  trrs_tx_type tx_st_ff;
  logic [4:0] slot_ff;
  logic [7:0] tsub_ff;
  logic [3:0] idx_ff;
  logic [7:0] ext_sub_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic sw_reset_req_ff;
  logic [7:0] sw_reset_kind_ff;
  logic [NS-1:0] set_v;
  logic [NS-1:0] clr_v;
  logic cmd_go;
  logic rst_cmd;
  logic apb_acc;
  logic tx_take;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign sw_reset_req = sw_reset_req_ff;
  assign sw_reset_kind = sw_reset_kind_ff;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so pready comes from a flop
  assign apb_acc = psel & penable & pready_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      if (psel & penable & ~pready_ff)
      begin
        unique case (paddr)
          OFS_MASK: prdata_ff <= {24'h0, mask_ff};
          OFS_OPT: prdata_ff <= opt_ff;
          OFS_STAT: prdata_ff <= {24'h0, ext_sub_ff[6:0], quiet_ff};
          OFS_PEND: prdata_ff <= {4'h0, pend_ff};
          default: pslverr_ff <= 1'b1; // unmapped: error, data zero
        endcase
      end
    end
  end

  // software-written settings steer the broadcast gating
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mask_ff <= RST_MASK;
      opt_ff <= RST_OPT;
    end
    else if (apb_acc && pwrite)
    begin
      if (paddr == OFS_MASK)
        mask_ff <= pwdata[7:0];
      if (paddr == OFS_OPT)
        opt_ff <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up quiet window and one-second tick
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      quiet_ff <= 1'b1;
      quiet_cnt_ff <= '0;
    end
    else if (quiet_ff)
    begin
      quiet_cnt_ff <= quiet_cnt_ff + 1'b1;
      if (quiet_cnt_ff == CNT_W'(QUIET_CYCLES - 1))
        quiet_ff <= 1'b0;
    end
  end

  // tick pulse is one cycle wide, so each second queues once
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sec_cnt_ff <= '0;
      sec_tick_ff <= 1'b0;
    end
    else
    begin
      sec_tick_ff <= (sec_cnt_ff == CNT_W'(SEC_CYCLES - 1));
      if (sec_cnt_ff == CNT_W'(SEC_CYCLES - 1))
        sec_cnt_ff <= '0;
      else
        sec_cnt_ff <= sec_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive deframer: keeps identifier and first unstuffed data byte
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rx_st_ff <= R_HUNT;
      cmd_ff <= '0;
      got_sub_ff <= 1'b0;
      cmd_done_ff <= 1'b0;
    end
    else
    begin
      cmd_done_ff <= 1'b0;
      if (rx_valid)
      begin
        unique case (rx_st_ff)
          R_HUNT: if (rx_byte == DLE) rx_st_ff <= R_DLE;
          R_DLE:
          begin
            if (rx_byte == DLE || rx_byte == ETX)
              rx_st_ff <= R_HUNT;
            else
            begin
              cmd_ff <= '{id: rx_byte, sub: 8'h00};
              got_sub_ff <= 1'b0;
              rx_st_ff <= R_BODY;
            end
          end
          R_BODY:
          begin
            if (rx_byte == DLE)
              rx_st_ff <= R_BDLE;
            else if (!got_sub_ff)
            begin
              cmd_ff.sub <= rx_byte;
              got_sub_ff <= 1'b1;
            end
          end
          R_BDLE:
          begin
            if (rx_byte == DLE)
            begin
              rx_st_ff <= R_BODY; // doubled byte is one data byte
              if (!got_sub_ff)
              begin
                cmd_ff.sub <= DLE;
                got_sub_ff <= 1'b1;
              end
            end
            else if (rx_byte == ETX)
            begin
              rx_st_ff <= R_HUNT;
              cmd_done_ff <= 1'b1;
            end
            else
              rx_st_ff <= R_DROP; // lone escape: discard frame
          end
          R_DROP: if (rx_byte == DLE) rx_st_ff <= R_DLE;
        endcase
      end
    end
  end

  // commands finishing inside the quiet window vanish with their data
  assign cmd_go = cmd_done_ff & ~quiet_ff;
  assign rst_cmd = cmd_go && cmd_ff.id == C_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // queue requests: broadcasts gated, explicit requests always answered
  always_comb
  begin
    set_v = '0;
    if (fix_done && mask_ff[MB_AUTO])
      set_v = set_v | fix_rpts(opt_ff);
    if (sec_tick_ff && mask_ff[MB_AUTO])
    begin
      set_v[S_P47] = 1'b1;
      set_v[S_P6C] = 1'b1;
    end
    if (sec_tick_ff)
    begin
      set_v[S_TM1] = mask_ff[MB_TIM1];
      set_v[S_TM2] = mask_ff[MB_TIM2];
    end
    if (meas_new && mask_ff[MB_AUTO] && opt_ff[AO_RAW])
      set_v[S_P5A] = 1'b1;
    if (cmd_go)
    begin
      // request answers bypass mask and options; the last-fix fix reports still follow both
      unique case (cmd_ff.id)
        C_HWVER: set_v[S_P1C] = 1'b1;
        C_RESET: set_v[S_VER] = 1'b1;
        C_SWVER: set_v[S_VER] = 1'b1;
        C_TIME: set_v[S_P41] = 1'b1;
        C_SVSEL: set_v[S_P6C] = 1'b1;
        C_HEALTH:
        begin
          set_v[S_P46] = 1'b1;
          set_v[S_P4B] = 1'b1;
        end
        C_SIG: set_v[S_P47] = 1'b1;
        C_SETTIME: set_v[S_P4E] = 1'b1;
        C_ROLL: set_v[S_P30] = 1'b1;
        C_POSXYZ, C_POSLLA: set_v = set_v;
        C_IOOPT: set_v[S_P55] = 1'b1;
        C_LASTFIX:
        begin
          set_v[S_P57] = 1'b1;
          if (mask_ff[MB_AUTO])
            set_v = set_v | fix_rpts(opt_ff);
        end
        C_SYSDATA: set_v[S_P58] = 1'b1;
        C_SVEN: set_v[S_P59] = 1'b1;
        C_RAW: set_v[S_P5A] = 1'b1;
        C_TRACK: set_v[S_P5D] = 1'b1;
        C_INTERVAL: set_v[S_P7B] = 1'b1;
        C_RXCFG: set_v[S_PBB] = 1'b1;
        C_PORTCFG: set_v[S_PBC] = 1'b1;
        ID_EXT_CMD:
        begin
          if (cmd_ff.sub == SUB_TIM1)
            set_v[S_TM1] = 1'b1;
          else if (cmd_ff.sub == SUB_TIM2)
            set_v[S_TM2] = 1'b1;
          else
            set_v[S_EXT] = 1'b1;
        end
        default: set_v[S_P13] = 1'b1; // unknown identifier
      endcase
    end
  end

  // a set in the same cycle as the launch clear wins; a reset command drops every pending slot but the version
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      pend_ff <= NS'(1) << S_VER;
    else if (rst_cmd)
      pend_ff <= NS'(1) << S_VER;
    else
      pend_ff <= (pend_ff & ~clr_v) | set_v;
  end

  // reset request handed to the core; kind is the command's first data byte
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sw_reset_req_ff <= 1'b0;
      sw_reset_kind_ff <= '0;
      ext_sub_ff <= '0;
    end
    else
    begin
      sw_reset_req_ff <= rst_cmd;
      if (rst_cmd)
        sw_reset_kind_ff <= cmd_ff.sub;
      if (cmd_go && cmd_ff.id == ID_EXT_CMD)
        ext_sub_ff <= cmd_ff.sub;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit framer; payload bytes are produced most significant first
  function automatic logic [7:0] pay_byte(input logic [4:0] s,
                                          input logic [3:0] i,
                                          input logic [7:0] sub);
    if (i == 4'd0)
      pay_byte = SLOT_ID[s];
    else if (s == 5'(S_VER))
      pay_byte = VER_BYTE[i - 4'd1];
    else
      pay_byte = sub;
  endfunction

  function automatic logic [3:0] pay_len(input logic [4:0] s);
    if (s == 5'(S_VER))
      pay_len = 4'(VER_LEN + 1);
    else if (SLOT_ID[s] == ID_EXT_RPT)
      pay_len = 4'd2;
    else
      pay_len = 4'd1;
  endfunction

  assign tx_take = tx_valid_ff & tx_ready;

  always_comb
  begin
    clr_v = '0;
    if (tx_st_ff == T_IDLE && pend_ff != '0)
      clr_v[first_one(pend_ff)] = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      tx_st_ff <= T_IDLE;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= '0;
      slot_ff <= '0;
      tsub_ff <= '0;
      idx_ff <= '0;
    end
    else
    begin
      unique case (tx_st_ff)
        T_IDLE:
        begin
          if (pend_ff != '0)
          begin
            slot_ff <= first_one(pend_ff);
            unique case (first_one(pend_ff))
              5'(S_TM1): tsub_ff <= SUB_TIM1;
              5'(S_TM2): tsub_ff <= SUB_TIM2;
              default: tsub_ff <= ext_sub_ff;
            endcase
            tx_valid_ff <= 1'b1;
            tx_data_ff <= DLE;
            tx_st_ff <= T_SOF;
          end
        end
        T_SOF:
        begin
          if (tx_take)
          begin
            idx_ff <= '0;
            tx_data_ff <= pay_byte(slot_ff, 4'd0, tsub_ff);
            tx_st_ff <= T_BODY;
          end
        end
        T_BODY, T_STUF:
        begin
          if (tx_take)
          begin
            if (tx_st_ff == T_BODY && idx_ff != 4'd0 && tx_data_ff == DLE)
              tx_st_ff <= T_STUF;
            else if (idx_ff + 4'd1 == pay_len(slot_ff))
            begin
              tx_data_ff <= DLE;
              tx_st_ff <= T_EOF;
            end
            else
            begin
              idx_ff <= idx_ff + 4'd1;
              tx_data_ff <= pay_byte(slot_ff, idx_ff + 4'd1, tsub_ff);
              tx_st_ff <= T_BODY;
            end
          end
        end
        T_EOF:
        begin
          if (tx_take)
          begin
            tx_data_ff <= ETX;
            tx_st_ff <= T_ETX;
          end
        end
        T_ETX:
        begin
          if (tx_take)
          begin
            tx_valid_ff <= 1'b0;
            tx_st_ff <= T_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ver_reset;
    @(posedge clk_sys) $rose(rst_b) |-> pend_ff[S_VER] && tx_st_ff == T_IDLE;
  endproperty
  a_ver_reset: assert property (p_ver_reset) else $error("no version after reset");

  property p_fix;
    @(posedge clk_sys) disable iff (!rst_b)
      fix_done && mask_ff[MB_AUTO] && opt_ff[PO_LLA] && !rst_cmd |=> pend_ff[S_P4A];
  endproperty
  a_fix: assert property (p_fix) else $error("fix report not queued");

  property p_dbl;
    @(posedge clk_sys) disable iff (!rst_b)
      fix_done && !mask_ff[MB_AUTO] && !(cmd_go && cmd_ff.id == C_LASTFIX)
      |=> !$rose(pend_ff[S_P83]);
  endproperty
  a_dbl: assert property (p_dbl) else $error("masked fix report queued");

  property p_sec;
    @(posedge clk_sys) disable iff (!rst_b)
      sec_tick_ff && mask_ff[MB_AUTO] && !rst_cmd |=> pend_ff[S_P47] && pend_ff[S_P6C];
  endproperty
  a_sec: assert property (p_sec) else $error("second reports missing");

  property p_tim;
    @(posedge clk_sys) disable iff (!rst_b)
      sec_tick_ff && mask_ff[MB_TIM1] && !rst_cmd |=> pend_ff[S_TM1];
  endproperty
  a_tim: assert property (p_tim) else $error("timing report missing");

  property p_quiet;
    @(posedge clk_sys) disable iff (!rst_b) quiet_ff |-> !cmd_go;
  endproperty
  a_quiet: assert property (p_quiet) else $error("command taken while quiet");

  property p_nopos;
    @(posedge clk_sys) disable iff (!rst_b)
      cmd_go && cmd_ff.id == C_POSXYZ && !fix_done && !sec_tick_ff && !meas_new
      |-> set_v == '0;
  endproperty
  a_nopos: assert property (p_nopos) else $error("position load answered");

  property p_frame;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(tx_valid_ff) |-> tx_data_ff == DLE && tx_st_ff == T_SOF;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start wrong");

  property p_lastfix;
    @(posedge clk_sys) disable iff (!rst_b)
      cmd_go && cmd_ff.id == C_LASTFIX |=> pend_ff[S_P57];
  endproperty
  a_lastfix: assert property (p_lastfix) else $error("fix info not queued");

  c_ver_sent: cover property (@(posedge clk_sys) tx_take && tx_st_ff == T_ETX && slot_ff == 0);
  c_stuff: cover property (@(posedge clk_sys) tx_st_ff == T_STUF);
  c_ext: cover property (@(posedge clk_sys) cmd_go && cmd_ff.id == ID_EXT_CMD);

endmodule

// ==== verif/trrs_host.sv ====
// host model: sends command frames, takes report bytes and unstuffs them
// assumes one clock; stalls tx_ready at random
`timescale 1ns/1ps
module trrs_host
  import trrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  int seed = 1064;
  logic [7:0] got [$];
  bit inf = 0;
  bit dl = 0;
  initial
  begin
    tx_ready = 0;
    rx_valid = 0;
    rx_byte = 8'h00;
  end
  ////////////////////////////////////////
  // random stalls make the framer hold some bytes
  always @(posedge clk_sys)
    tx_ready <= ($random(seed) % 3) != 0;
  // unstuff; a frame ends on etx after an odd dle
  always @(posedge clk_sys)
    if (tx_valid && tx_ready)
    begin
      if (!inf)
        inf = (tx_data == DLE);
      else if (dl)
      begin
        dl = 0;
        if (tx_data == ETX)
          inf = 0;
        else
          got.push_back(tx_data);
      end
      else if (tx_data == DLE)
        dl = 1;
      else
        got.push_back(tx_data);
    end
  ////////////////////////////////////////
  task automatic put(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1;
    rx_byte <= b;
  endtask
  // one command with one data byte; idle line shows a changed value
  task automatic send(input logic [7:0] id, input logic [7:0] d);
    put(DLE);
    put(id);
    put(d);
    if (d == DLE)
      put(DLE);
    put(DLE);
    put(ETX);
    @(posedge clk_sys);
    rx_valid <= 0;
    rx_byte <= ~d;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// bench: drives commands and apb, compares report bytes with a queue model
// assumes trrs_host as far side; quiet and second counts shortened
`timescale 1ns/1ps
module tb_top
  import trrs_pkg::*;
  ;
  localparam int SC = 200;
  localparam logic [7:0] REQ [14] = '{8'h21, 8'h24, 8'h27, 8'h30, 8'h35, 8'h38,
    8'h39, 8'h3A, 8'h3C, 8'h7A, 8'h1C, 8'hBB, 8'hBC, 8'h2E};
  localparam logic [7:0] RSP [14] = '{8'h41, 8'h6C, 8'h47, 8'h30, 8'h55, 8'h58,
    8'h59, 8'h5A, 8'h5D, 8'h7B, 8'h1C, 8'hBB, 8'hBC, 8'h4E};
  localparam logic [7:0] TMQ [4] = '{8'h8F, 8'hAB, 8'h8F, 8'hAC};
  logic clk_sys = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, tx_valid, tx_ready, rx_valid, sw_reset_req;
  logic fix_done = 0;
  logic meas_new = 0;
  logic [7:0] tx_data, rx_byte, sw_reset_kind;
  logic [7:0] exp [$];
  logic [7:0] tq [$];
  int seed = 1064;
  int mismatches = 0;
  int compares = 0;
  int nrst = 0;
  initial
    forever #50 clk_sys = ~clk_sys;
  trrs_sched #(.QUIET_CYCLES(50), .SEC_CYCLES(SC)) u_trrs_sched (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .fix_done(fix_done), .meas_new(meas_new), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .sw_reset_req(sw_reset_req),
    .sw_reset_kind(sw_reset_kind));
  trrs_host u_trrs_host (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
  always @(posedge clk_sys)
    if (sw_reset_req === 1'b1)
      nrst++;
  ////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  // apb cycle; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // only the watchdog ends a wait that never sees pready
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse;
    @(posedge clk_sys);
    fix_done <= 1;
    meas_new <= 1;
    @(posedge clk_sys);
    fix_done <= 0;
    meas_new <= 0;
  endtask
  function automatic void ver();
    exp.push_back(8'h45);
    foreach (VER_BYTE[i])
      exp.push_back(VER_BYTE[i]);
  endfunction
  // wait for the model's count, then a while more so extras show up
  task automatic drain(input string nm, input bit flt);
    logic [7:0] g [$];
    int n = 0;
    while (u_trrs_host.got.size() < exp.size() && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (60) @(posedge clk_sys);
    foreach (u_trrs_host.got[i])
      if (!flt || !(u_trrs_host.got[i] inside {8'h47, 8'h6C}))
        g.push_back(u_trrs_host.got[i]);
    chk({nm, " count"}, exp.size(), g.size());
    foreach (exp[i])
      chk({nm, " byte"}, exp[i], i < g.size() ? g[i] : 8'hXX);
    u_trrs_host.got.delete();
    exp.delete();
    $display("test %0s done", nm);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #(100 * 20000);
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1;
    u_trrs_host.send(C_TIME, 8'h00);
    apb(0, OFS_MASK, 0);
    chk("mask reset", RST_MASK, rd);
    apb(0, OFS_OPT, 0);
    chk("opt reset", RST_OPT, rd);
    apb(0, 8'h10, 0);
    chk("unmapped error", 1, er);
    apb(1, OFS_MASK, 0);
    ver();
    drain("reset", 0);
    foreach (REQ[i])
    begin
      exp.push_back(RSP[i]);
      u_trrs_host.send(REQ[i], 8'($random(seed)));
      drain("request", 0);
    end
    ver();
    u_trrs_host.send(C_SWVER, 8'h00);
    drain("version", 0);
    exp = {8'h46, 8'h4B};
    u_trrs_host.send(C_HEALTH, 8'h00);
    drain("health", 0);
    u_trrs_host.send(C_POSXYZ, 8'h10);
    u_trrs_host.send(C_POSLLA, 8'h00);
    drain("position load", 0);
    for (int k = 0; k < 2; k++)
    begin
      exp = {8'h8F, k ? 8'h10 : 8'h26};
      u_trrs_host.send(ID_EXT_CMD, k ? 8'h10 : 8'h26);
      drain("extended", 0);
    end
    apb(0, OFS_STAT, 0);
    chk("status", 32'h0000_0020, rd);
    exp = {8'h57};
    u_trrs_host.send(C_LASTFIX, 8'h00);
    drain("last fix", 0);
    exp = {8'h13};
    u_trrs_host.send(8'h99, 8'h00);
    drain("unknown", 0);
    // fix and measurement broadcasts; per-second lists filtered out
    apb(1, OFS_OPT, 32'h0100_0313);
    apb(1, OFS_MASK, 32'h0000_0040);
    exp = {8'h42, 8'h43, 8'h4A, 8'h56, 8'h83, 8'h84, 8'h5A};
    pulse();
    drain("broadcast", 1);
    exp = {8'h42, 8'h43, 8'h4A, 8'h56, 8'h83, 8'h84, 8'h57};
    u_trrs_host.send(C_LASTFIX, 8'h00);
    drain("fix request", 1);
    // timing reports each second, then nothing once masked
    apb(1, OFS_MASK, 32'h0000_0005);
    repeat (2 * SC + 50) @(posedge clk_sys);
    apb(1, OFS_MASK, 0);
    pulse();
    repeat (60) @(posedge clk_sys);
    // list reports queued just before the mask change may still trail in
    foreach (u_trrs_host.got[i])
      if (!(u_trrs_host.got[i] inside {8'h47, 8'h6C}))
        tq.push_back(u_trrs_host.got[i]);
    chk("timing count", 0, tq.size() % 4);
    chk("timing seen", 1, tq.size() >= 8);
    foreach (tq[i])
      chk("timing byte", TMQ[i % 4], tq[i]);
    u_trrs_host.got.delete();
    $display("test timing done");
    ver();
    u_trrs_host.send(C_RESET, 8'h02);
    drain("reset command", 0);
    chk("reset kind", 8'h02, sw_reset_kind);
    chk("reset pulses", 1, nrst);
    // pin reset in mid-run must bring the version report again
    rst_b <= 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    ver();
    drain("pin reset", 0);
    report_and_stop;
  end
endmodule
